//--- mass_pkg.sv
// mass_pkg: constants, register map and types shared by the supply sequencer
// assumes a 20 MHz system clock and a 32-bit apb register port
package mass_pkg;

   // clock and timing
   localparam int CLK_HZ                    = 20_000_000;
   localparam int CLK_PER_US                = CLK_HZ / 1_000_000;
   localparam int OFFSET_TO_BIAS_DELAY_US   = 2000;
   localparam int OFFSET_TO_BIAS_MIN_US     = 1000;
   localparam int OFFSET_TO_BIAS_CYCLES     = OFFSET_TO_BIAS_DELAY_US * CLK_PER_US;
   localparam int OFFSET_TO_BIAS_MIN_CYCLES = OFFSET_TO_BIAS_MIN_US * CLK_PER_US;
   localparam int POWER_GOOD_HOLD_DELAY_NS  = 100;
   localparam int POWER_GOOD_HOLD_CYCLES    =
      (POWER_GOOD_HOLD_DELAY_NS * CLK_PER_US + 999) / 1000;

   // i2c sensor link
   localparam int       I2C_QUARTER_DIV    = 50;
   localparam int       I2C_FRAME_BITS     = 27;
   localparam int       I2C_ADDR_BITS      = 7;
   localparam logic [6:0] I2C_SENSOR_ADDR  = 7'h48;

   // register offsets (byte addresses)
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_ERR    = 8'h08;
   localparam logic [7:0] REG_TEMP   = 8'h0C;

   // ctrl fields (write one to request)
   localparam int CTRL_POWER_UP   = 0;
   localparam int CTRL_POWER_DOWN = 1;
   localparam int CTRL_TEMP_READ  = 2;

   // err fields (sticky, write one to clear)
   localparam int ERR_PG_EARLY    = 0;
   localparam int ERR_EMERGENCY   = 1;
   localparam int ERR_PG_BEFORE_OE = 2;
   localparam int ERR_I2C_NACK    = 3;
   localparam int ERR_W           = 4;
   localparam logic [ERR_W-1:0] ERR_RESET = 4'h0;

   typedef enum logic [10:0] {
      ST_OFF       = 11'h001,
      ST_LOGIC_UP  = 11'h002,
      ST_RESET_OE  = 11'h004,
      ST_OFFSET_UP = 11'h008,
      ST_BIAS_WAIT = 11'h010,
      ST_ACTIVE    = 11'h020,
      ST_PARK      = 11'h040,
      ST_SUPPLY_DN = 11'h080,
      ST_PG_HOLD   = 11'h100,
      ST_DISCHARGE = 11'h200,
      ST_EMERG     = 11'h400
   } mass_state_t;

   typedef struct packed {
      logic logic_en;
      logic offset_en;
      logic bias_en;
      logic reset_en;
   } mass_supply_en_t;

   typedef struct packed {
      logic logic_good;
      logic offset_good;
      logic discharged;
   } mass_supply_good_t;

endpackage

//--- mass_temp_reader.sv
// mass_temp_reader: i2c master that reads a 16-bit word from the sensor
// assumes open-drain pins resolved outside; sensor pointer left at its default
`timescale 1ns/100ps
module mass_temp_reader #(
   parameter int         QUARTER_DIV = mass_pkg::I2C_QUARTER_DIV,
   parameter logic [6:0] SENSOR_ADDR = mass_pkg::I2C_SENSOR_ADDR
)(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        start,
   output logic             busy,
   output logic             done,
   output logic             nack,
   output logic [15:0]      data,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe
);
   import mass_pkg::*;

   typedef enum logic [3:0] {
      I_IDLE  = 4'h1,
      I_START = 4'h2,
      I_BITS  = 4'h4,
      I_STOP  = 4'h8
   } mass_i2c_t;

   localparam int DW = $clog2(QUARTER_DIV + 1);

   generate
      if (QUARTER_DIV < 2)
      begin : g_chk
         $error("quarter divider too small");
      end
   endgenerate

   mass_i2c_t         st;
   logic [DW-1:0]     div;
   logic [1:0]        ph;
   logic [4:0]        bitn;
   logic [7:0]        addr_byte;
   logic              tick;
   logic              drive_low;

   // stretching: scl released but still held low holds the divider
   assign tick      = (div == DW'(QUARTER_DIV - 1)) && !(ph == 2'd2 && !scl_i && !scl_oe);
   assign addr_byte = {SENSOR_ADDR, 1'b1};
   assign scl_o     = 1'b0;
   assign sda_o     = 1'b0;
   assign busy      = (st != I_IDLE);

   always_comb
   begin
      drive_low = 1'b0;
      if (bitn < 5'd8)
         drive_low = !addr_byte[3'd7 - bitn[2:0]];
      else if (bitn == 5'd17)
         drive_low = 1'b1;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         div <= '0;
      else if (st == I_IDLE || tick)
         div <= '0;
      else if (!(ph == 2'd2 && !scl_i && !scl_oe))
         div <= div + 1'b1;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st     <= I_IDLE;
         ph     <= 2'd0;
         bitn   <= 5'd0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         done   <= 1'b0;
         nack   <= 1'b0;
         data   <= 16'h0000;
      end
      else
      begin
         done <= 1'b0;
         case (st)
            I_IDLE:
            begin
               if (start)
               begin
                  st     <= I_START;
                  ph     <= 2'd0;
                  nack   <= 1'b0;
                  sda_oe <= 1'b1;
               end
            end
            I_START:
            begin
               if (tick)
               begin
                  scl_oe <= 1'b1;
                  st     <= I_BITS;
                  bitn   <= 5'd0;
               end
            end
            I_BITS:
            begin
               if (tick)
               begin
                  ph <= ph + 2'd1;
                  case (ph)
                     2'd0: sda_oe <= drive_low;
                     2'd1: scl_oe <= 1'b0;
                     2'd2:
                     begin
                        if (bitn == 5'd8)
                           nack <= sda_i;
                        else if (bitn > 5'd8 && bitn != 5'd17 && bitn != 5'd26)
                           data <= {data[14:0], sda_i};
                     end
                     default:
                     begin
                        scl_oe <= 1'b1;
                        if (bitn == 5'(I2C_FRAME_BITS - 1))
                           st <= I_STOP;
                        else
                           bitn <= bitn + 5'd1;
                     end
                  endcase
               end
            end
            I_STOP:
            begin
               if (tick)
               begin
                  ph <= ph + 2'd1;
                  case (ph)
                     2'd0: sda_oe <= 1'b1;
                     2'd1: scl_oe <= 1'b0;
                     2'd2: sda_oe <= 1'b0;
                     default:
                     begin
                        st   <= I_IDLE;
                        done <= 1'b1;
                     end
                  endcase
               end
            end
            default: st <= I_IDLE;
         endcase
      end
   end
endmodule

//--- mass_sequencer.sv
// mass_sequencer: supply sequencing controller for a micromirror array
// assumes an apb master for control and a pmic giving power-good levels
//
// Functional notes
// - only this controller switches the array supplies, never anyone else
// - logic supply settles before offset, bias and reset supplies come on; supply loss in ST_LOGIC_UP enables them at once in ST_EMERG
// - bias supply enabled only after offset supply, with the offset-to-bias gap; supply loss before ST_ACTIVE enables bias at once in ST_EMERG
// - reset supply free relative to bias; here switched together with it
// - cmos inputs of the array stay low until logic supply settles
// - logic supply stays on until all mirror supplies have discharged
// - normal shutdown: offset good falls only after offset enable, after a hold
// - mirror supplies enabled only after the reset output-enable is high; supply loss in ST_LOGIC_UP raises both in the same cycle
// - a global bias command parks all mirrors before normal power-down
// - after parking, power-down strobe asserts and mirror supplies turn off
// - supply loss runs an emergency park; offset enable may drop after good
// - emergency: output-enable driven high before offset good falls
// - die temperature read over i2c from the external sensor
// - offset settled to bias and reset up is at least 1 ms, 2 ms nominal
// - offset good holds at least 100 ns after offset enable goes low
`timescale 1ns/100ps
module mass_sequencer #(
   parameter int BIAS_DELAY_CYCLES = mass_pkg::OFFSET_TO_BIAS_CYCLES
)(
   input  wire logic                       clk,
   input  wire logic                       rstn,
   input  wire logic [7:0]                 paddr,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   output mass_pkg::mass_supply_en_t       supply_en,
   input  wire mass_pkg::mass_supply_good_t supply_good,
   input  wire logic                       supply_loss,
   output logic                            array_reset_output_enable_n,
   output logic                            array_output_enable_n,
   output logic                            power_down_strobe_n,
   output logic                            lvcmos_drive_en,
   output logic                            park_cmd,
   input  wire logic                       park_done,
   input  wire logic                       scl_i,
   output logic                            scl_o,
   output logic                            scl_oe,
   input  wire logic                       sda_i,
   output logic                            sda_o,
   output logic                            sda_oe
);
   import mass_pkg::*;

   localparam int TW = $clog2(BIAS_DELAY_CYCLES + 1);

   generate
      // refuse a gap below 1 ms
      if (BIAS_DELAY_CYCLES < OFFSET_TO_BIAS_MIN_CYCLES)
      begin : g_chk_delay
         $error("offset-to-bias delay below minimum");
      end
      if (POWER_GOOD_HOLD_CYCLES < 1)
      begin : g_chk_hold
         $error("power-good hold below one cycle");
      end
   endgenerate

   mass_state_t       state;
   mass_state_t       next_state;
   logic [TW-1:0]     timer;
   logic              timer_load;
   logic              timer_done;
   logic              wr_acc;
   logic              rd_setup;
   logic              addr_ok;
   logic              req_up;
   logic              req_down;
   logic              req_temp;
   logic              pending_up;
   logic              pending_down;
   logic [ERR_W-1:0]  err;
   logic [ERR_W-1:0]  err_set;
   logic [ERR_W-1:0]  err_clr;
   logic              temp_busy;
   logic              temp_done;
   logic              temp_nack;
   logic [15:0]       temp_raw;
   logic [15:0]       temp_word;
   logic              in_use;

   // ---------------- apb slave ----------------
   // zero-wait slave: read data is captured in the setup cycle
   assign pready   = 1'b1;
   assign addr_ok  = (paddr == REG_CTRL) || (paddr == REG_STATUS) ||
                     (paddr == REG_ERR) || (paddr == REG_TEMP);
   assign wr_acc   = psel && penable && pwrite && addr_ok;
   assign rd_setup = psel && !penable;
   assign req_up   = wr_acc && (paddr == REG_CTRL) && pwdata[CTRL_POWER_UP];
   assign req_down = wr_acc && (paddr == REG_CTRL) && pwdata[CTRL_POWER_DOWN];
   assign req_temp = wr_acc && (paddr == REG_CTRL) && pwdata[CTRL_TEMP_READ];
   assign err_clr  = (wr_acc && (paddr == REG_ERR)) ? pwdata[ERR_W-1:0] : '0;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (rd_setup)
      begin
         pslverr <= !addr_ok;
         prdata  <= 32'h0000_0000;
         if (!pwrite)
         begin
            case (paddr)
               REG_CTRL:   prdata <= {29'h0, temp_busy, pending_down, pending_up};
               REG_STATUS: prdata <= {12'h0, supply_good, array_output_enable_n,
                                      power_down_strobe_n, supply_en, 
                                      state};
               REG_ERR:    prdata <= {28'h0, err};
               REG_TEMP:   prdata <= {16'h0, temp_word};
               default:    prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // requests are remembered until the sequencer can act on them
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pending_up   <= 1'b0;
         pending_down <= 1'b0;
      end
      else
      begin
         pending_up   <= req_up || (pending_up && state != ST_OFF);
         pending_down <= req_down || (pending_down && state != ST_ACTIVE);
      end
   end

   // a new event wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         err <= ERR_RESET;
      else
         err <= (err & ~err_clr) | err_set;
   end

   // ---------------- sequencer ----------------
   assign in_use     = (state != ST_OFF) && (state != ST_DISCHARGE) && (state != ST_EMERG);
   assign timer_done = (timer == '0);
   assign timer_load = (next_state != state) &&
                       (next_state == ST_BIAS_WAIT || next_state == ST_PG_HOLD);

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         timer <= '0;
      else if (timer_load)
         timer <= (next_state == ST_BIAS_WAIT) ? TW'(BIAS_DELAY_CYCLES - 1)
                                               : TW'(POWER_GOOD_HOLD_CYCLES - 1);
      else if (!timer_done)
         timer <= timer - 1'b1;
   end

   always_comb
   begin
      next_state = state;
      err_set    = '0;
      // supply loss forces the emergency park
      if (in_use && supply_loss)
      begin
         next_state              = ST_EMERG;
         err_set[ERR_EMERGENCY]  = 1'b1;
      end
      else
      begin
         case (state)
            ST_OFF:
               if (pending_up)
                  next_state = ST_LOGIC_UP;
            ST_LOGIC_UP:
               if (supply_good.logic_good)
                  next_state = ST_RESET_OE;
            ST_RESET_OE:
               next_state = ST_OFFSET_UP;
            ST_OFFSET_UP:
               if (supply_good.offset_good)
                  next_state = ST_BIAS_WAIT;
            ST_BIAS_WAIT:
               if (timer_done)
                  next_state = ST_ACTIVE;
            ST_ACTIVE:
               if (pending_down)
                  next_state = ST_PARK;
            ST_PARK:
               if (park_done)
                  next_state = ST_SUPPLY_DN;
            ST_SUPPLY_DN:
               next_state = ST_PG_HOLD;
            ST_PG_HOLD:
            begin
               if (!supply_good.offset_good && !timer_done)
                  err_set[ERR_PG_EARLY] = 1'b1;
               if (timer_done)
                  next_state = ST_DISCHARGE;
            end
            ST_DISCHARGE:
               if (supply_good.discharged)
                  next_state = ST_OFF;
            ST_EMERG:
            begin
               // good falling before output-enable is high
               if (!supply_good.offset_good && !array_output_enable_n)
                  err_set[ERR_PG_BEFORE_OE] = 1'b1;
               if (park_done || !supply_good.offset_good)
                  next_state = ST_DISCHARGE;
            end
            default:
               next_state = ST_OFF;
         endcase
      end
      if (temp_done && temp_nack)
         err_set[ERR_I2C_NACK] = 1'b1;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         state <= ST_OFF;
      else
         state <= next_state;
   end

   // ---------------- pin drive ----------------
   // supplies driven only from the sequencer state
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         supply_en <= '0;
      else
      begin
         supply_en.logic_en  <= (next_state != ST_OFF);
         supply_en.offset_en <= (next_state == ST_OFFSET_UP) || (next_state == ST_BIAS_WAIT) ||
                                (next_state == ST_ACTIVE) || (next_state == ST_PARK) ||
                                (next_state == ST_EMERG);
         supply_en.bias_en   <= (next_state == ST_ACTIVE) || (next_state == ST_PARK) ||
                                (next_state == ST_EMERG);
         supply_en.reset_en  <= (next_state == ST_ACTIVE) || (next_state == ST_PARK) ||
                                (next_state == ST_EMERG);
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         array_reset_output_enable_n <= 1'b0;
         lvcmos_drive_en             <= 1'b0;
      end
      else
      begin
         // reset output-enable high ahead of mirror supplies; with them on supply loss in ST_LOGIC_UP
         array_reset_output_enable_n <= !(next_state == ST_OFF || next_state == ST_LOGIC_UP ||
                                          next_state == ST_DISCHARGE);
         // no cmos drive before logic supply settled
         lvcmos_drive_en <= supply_good.logic_good && (next_state != ST_OFF) &&
                            (next_state != ST_LOGIC_UP) && (next_state != ST_DISCHARGE);
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         array_output_enable_n <= 1'b1;
         power_down_strobe_n   <= 1'b0;
         park_cmd              <= 1'b0;
      end
      else
      begin
         // outputs disabled at once on emergency
         array_output_enable_n <= (next_state != ST_ACTIVE);
         // strobe low from supply turn-off or emergency entry until next power-up
         if (next_state == ST_SUPPLY_DN || next_state == ST_EMERG)
            power_down_strobe_n <= 1'b0;
         else if (next_state == ST_RESET_OE)
            power_down_strobe_n <= 1'b1;
         // one-cycle global bias command on park entry
         park_cmd <= (next_state != state) &&
                     (next_state == ST_PARK || next_state == ST_EMERG);
      end
   end

   // ---------------- temperature ----------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         temp_word <= 16'h0000;
      else if (temp_done && !temp_nack)
         temp_word <= temp_raw;
   end

   mass_temp_reader #(
      .QUARTER_DIV (I2C_QUARTER_DIV),
      .SENSOR_ADDR (I2C_SENSOR_ADDR)
   ) u_temp (
      .clk    (clk),
      .rstn   (rstn),
      .start  (req_temp),
      .busy   (temp_busy),
      .done   (temp_done),
      .nack   (temp_nack),
      .data   (temp_raw),
      .scl_i  (scl_i),
      .scl_o  (scl_o),
      .scl_oe (scl_oe),
      .sda_i  (sda_i),
      .sda_o  (sda_o),
      .sda_oe (sda_oe)
   );

endmodule

//--- mass_sequencer_properties.sv
// mass_sequencer_properties: timing checks on the sequencer supply pins
// assumes a bind to mass_sequencer; one clock, asynchronous low reset
`timescale 1ns/100ps
module mass_sequencer_properties
   import mass_pkg::*;
#(
   parameter int BIAS_DELAY_CYCLES = OFFSET_TO_BIAS_CYCLES
)(
   input wire logic                        clk,
   input wire logic                        rstn,
   input wire mass_pkg::mass_supply_en_t   supply_en,
   input wire mass_pkg::mass_supply_good_t supply_good,
   input wire logic                        supply_loss,
   input wire logic                        array_reset_output_enable_n,
   input wire logic                        array_output_enable_n,
   input wire logic                        power_down_strobe_n,
   input wire logic                        lvcmos_drive_en,
   input wire logic                        park_cmd
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   int unsigned og_cnt;
   logic        parked;
   // cycles with offset settled; never wraps within a run
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
         og_cnt <= 0;
      else if (supply_good.offset_good && supply_en.offset_en)
         og_cnt <= og_cnt + 1;
      else
         og_cnt <= 0;
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
         parked <= 1'b0;
      else if (park_cmd)
         parked <= 1'b1;
      else if (!supply_en.offset_en)
         parked <= 1'b0;
   a_logic_first: assert property ($rose(supply_en.offset_en) |->
      supply_good.logic_good && supply_en.logic_en) else $error("offset on before logic");
   a_bias_gap: assert property ($rose(supply_en.bias_en) |->
      og_cnt >= BIAS_DELAY_CYCLES) else $error("bias enabled too early");
   a_reset_with_bias: assert property (
      supply_en.reset_en == supply_en.bias_en) else $error("reset supply apart from bias");
   a_cmos_after_logic: assert property (lvcmos_drive_en |->
      $past(supply_good.logic_good)) else $error("cmos before logic supply");
   a_logic_held: assert property ($fell(supply_en.logic_en) |->
      $past(supply_good.discharged) && supply_en == 4'h0) else $error("logic off too early");
   a_pg_order: assert property ($fell(supply_en.offset_en) && !$past(supply_loss) |->
      $past(supply_good.offset_good)) else $error("offset good fell before enable");
   a_oe_first: assert property ($rose(supply_en.offset_en) |->
      array_reset_output_enable_n) else $error("supplies before reset oe");
   a_oe_only_on: assert property (!array_output_enable_n |->
      supply_en == 4'hF) else $error("output enabled without supplies");
   a_park_pulse: assert property (park_cmd |=> !park_cmd)
      else $error("park pulse too long");
   a_park_first: assert property ($fell(power_down_strobe_n) |->
      parked || park_cmd) else $error("strobe without park");
   a_strobe_hv_off: assert property ($fell(supply_en.offset_en) |->
      !power_down_strobe_n) else $error("offset off without strobe");
   a_oe_before_pg: assert property ($fell(supply_good.offset_good) |->
      array_output_enable_n) else $error("offset good fell with output enabled");
endmodule

//--- mass_pmic_model.sv
// mass_pmic_model: regulators, mirror park handshake and i2c pull-ups
// assumes slow picks long settle and park times; no sensor answers on i2c
`timescale 1ns/100ps
module mass_pmic_model
   import mass_pkg::*;
(
   input  wire logic                        clk,
   input  wire logic                        rstn,
   input  wire logic                        slow,
   input  wire logic                        pg_drop,
   input  wire mass_pkg::mass_supply_en_t   supply_en,
   output mass_pkg::mass_supply_good_t      supply_good,
   input  wire logic                        park_cmd,
   output logic                             park_done,
   input  wire logic                        scl_oe,
   input  wire logic                        sda_oe,
   output logic                             scl_i,
   output logic                             sda_i
);
   int unsigned lg_cnt, og_cnt, off_cnt, hv_cnt, pk_cnt, dly;
   assign dly = slow ? 200 : 8;
   // released lines float to the pull-up, so an absent sensor reads as nack
   assign scl_i = ~scl_oe;
   assign sda_i = ~sda_oe;
   always_ff @(posedge clk or negedge rstn)
      if (!rstn)
      begin
         {lg_cnt, og_cnt, off_cnt, pk_cnt} <= '0;
         hv_cnt <= 1000;
         supply_good <= 3'b001;
         park_done <= 1'b0;
      end
      else
      begin
         lg_cnt <= supply_en.logic_en ? lg_cnt + 1 : 0;
         og_cnt <= supply_en.offset_en ? og_cnt + 1 : 0;
         off_cnt <= supply_en.offset_en ? 0 : off_cnt + 1;
         hv_cnt <= (|supply_en[2:0]) ? 0 : hv_cnt + 1;
         supply_good.logic_good <= supply_en.logic_en && lg_cnt >= dly;
         supply_good.discharged <= hv_cnt >= dly;
         // offset good holds four cycles past its enable
         if (pg_drop)
            supply_good.offset_good <= 1'b0;
         else if (supply_en.offset_en && og_cnt >= dly)
            supply_good.offset_good <= 1'b1;
         else if (!supply_en.offset_en && off_cnt >= 3)
            supply_good.offset_good <= 1'b0;
         // mirrors report parked some time after the command
         park_done <= pk_cnt == 1;
         if (park_cmd)
            pk_cnt <= dly;
         else if (pk_cnt != 0)
            pk_cnt <= pk_cnt - 1;
      end
endmodule

//--- tb_top.sv
// tb_top: bench for mass_sequencer over apb against the regulator model
// assumes a 20 MHz clock and the shortest legal offset-to-bias count
`timescale 1ns/100ps
module tb_top;
   import mass_pkg::*;
   localparam int BIAS = 20000;
   logic            clk, rstn, psel, penable, pwrite, pready, pslverr, err;
   logic            supply_loss, park_cmd, park_done, slow, pg_drop, lvcmos;
   logic            rst_oe_n, oe_n, strobe_n, scl_o, scl_oe, sda_o, sda_oe, scl_i, sda_i;
   logic [7:0]      paddr;
   logic [31:0]     pwdata, prdata, rd;
   mass_supply_en_t   sen;
   mass_supply_good_t sgood;
   int              mismatches, checked;
   realtime         t0;
   logic [7:0]      row_addr [5] = '{REG_CTRL, REG_STATUS, REG_ERR, REG_TEMP, 8'h10};
   logic [31:0]     row_data [5] = '{32'h0, 32'h30001, 32'h0, 32'h0, 32'h0};
   logic            row_err [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
   mass_sequencer #(.BIAS_DELAY_CYCLES(BIAS)) u_dut (.clk, .rstn, .paddr, .psel, .penable,
      .pwrite, .pwdata, .prdata, .pready, .pslverr, .supply_en(sen), .supply_good(sgood),
      .supply_loss, .array_reset_output_enable_n(rst_oe_n), .array_output_enable_n(oe_n),
      .power_down_strobe_n(strobe_n), .lvcmos_drive_en(lvcmos), .park_cmd, .park_done,
      .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe);
   mass_pmic_model u_pmic (.clk, .rstn, .slow, .pg_drop, .supply_en(sen), .supply_good(sgood),
      .park_cmd, .park_done, .scl_oe, .sda_oe, .scl_i, .sda_i);
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task report_and_stop;
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task fail_out;
      mismatches++;
      $display("Error at %0t: wait ran out", $time);
      report_and_stop;
   endtask
   task chk(input logic [39:0] seen, input logic [39:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // idle cycle after each transfer
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      for (int k = 0; pready !== 1'b1; k++)
      begin
         if (k > 20)
            fail_out;
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task wait_st(input logic [10:0] st, input logic [7:0] a = REG_STATUS);
      for (int k = 0; k < 15000; k++)
      begin
         apb(1'b0, a, 32'h0);
         if (rd[10:0] === st)
            return;
      end
      fail_out;
   endtask
   initial
   begin
      {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
      {supply_loss, slow, pg_drop, mismatches, checked} = '0;
      repeat (16) @(posedge clk);
      chk({sen, strobe_n, oe_n, rst_oe_n, lvcmos, park_cmd}, 40'h008);
      rstn <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 5; i++)
      begin
         apb(1'b0, row_addr[i], 32'h0);
         chk({err, rd}, {row_err[i], row_data[i]});
      end
      apb(1'b1, REG_CTRL, 32'h1);
      wait_st(ST_BIAS_WAIT);
      t0 = $realtime;
      wait_st(ST_ACTIVE);
      chk((($realtime - t0) / 50 >= BIAS - 6) && (($realtime - t0) / 50 <= BIAS + 6), 1);
      chk({sen, oe_n, rst_oe_n, strobe_n, lvcmos}, 40'hF7);
      // slow park and discharge so each state is polled
      slow <= 1'b1;
      apb(1'b1, REG_CTRL, 32'h2);
      wait_st(ST_PARK);
      chk({sen, oe_n, strobe_n}, 40'h3F);
      wait_st(ST_DISCHARGE);
      chk({sen, strobe_n}, 40'h10);
      wait_st(ST_OFF);
      apb(1'b0, REG_ERR, 32'h0);
      chk({rd, sen}, 40'h0);
      apb(1'b1, REG_CTRL, 32'h1);
      wait_st(ST_ACTIVE);
      supply_loss <= 1'b1;
      wait_st(ST_EMERG);
      chk({sen, oe_n, strobe_n}, 40'h3E);
      pg_drop <= 1'b1;
      wait_st(ST_OFF);
      apb(1'b0, REG_ERR, 32'h0);
      chk(rd, 40'h2);
      apb(1'b1, REG_ERR, 32'h2);
      apb(1'b0, REG_ERR, 32'h0);
      chk(rd, 40'h0);
      supply_loss <= 1'b0;
      pg_drop <= 1'b0;
      apb(1'b1, REG_CTRL, 32'h4);
      wait_st(11'h0, REG_CTRL);
      apb(1'b0, REG_ERR, 32'h0);
      chk(rd, 40'h8);
      apb(1'b1, REG_CTRL, 32'h2);
      apb(1'b0, REG_CTRL, 32'h0);
      chk(rd, 40'h2);
      report_and_stop;
   end
endmodule
bind mass_sequencer mass_sequencer_properties #(.BIAS_DELAY_CYCLES(BIAS_DELAY_CYCLES)) u_props (
   .clk, .rstn, .supply_en, .supply_good, .supply_loss, .array_reset_output_enable_n,
   .array_output_enable_n, .power_down_strobe_n, .lvcmos_drive_en, .park_cmd);
